// file: src/fsps_pkg.sv
package fsps_pkg;

   // ==========================================
   // Clock and timing
   // ==========================================
   localparam int unsigned CLK_MHZ         = 100;
   localparam int unsigned OP_MIN_US       = 3700;
   localparam int unsigned OP_MAX_US       = 4500;
   localparam int unsigned OP_MIN_CYCLES   = OP_MIN_US * CLK_MHZ;
   localparam int unsigned OP_MAX_CYCLES   = OP_MAX_US * CLK_MHZ;
   localparam int unsigned OP_CYCLES_DFLT  = OP_MIN_CYCLES + (OP_MAX_CYCLES - OP_MIN_CYCLES) / 2;
   localparam int unsigned ARM_WINDOW      = 4;
   localparam int unsigned TMR_W           = 20;

   // ==========================================
   // Flash geometry
   // ==========================================
   localparam int unsigned PAGE_WORDS      = 64;
   localparam int unsigned PAGE_BYTES      = 128;
   localparam int unsigned WORD_IDX_W      = 6;
   localparam int unsigned PAGE_IDX_W      = 7;
   localparam int unsigned WADDR_W         = 13;
   localparam int unsigned ZPTR_W          = 16;
   localparam int unsigned PAGE_IDX_LSB    = 7;
   localparam int unsigned WORD_IDX_LSB    = 1;

   // Boot section start per size setting, 8K and 16K variants
   localparam logic [12:0] BOOT8K_SZ3      = 13'h0_F00;
   localparam logic [12:0] BOOT8K_SZ2      = 13'h0_E00;
   localparam logic [12:0] BOOT8K_SZ1      = 13'h0_C00;
   localparam logic [12:0] BOOT8K_SZ0      = 13'h0_800;
   localparam logic [12:0] BOOT16K_SZ3     = 13'h1_F00;
   localparam logic [12:0] BOOT16K_SZ2     = 13'h1_E00;
   localparam logic [12:0] BOOT16K_SZ1     = 13'h1_C00;
   localparam logic [12:0] BOOT16K_SZ0     = 13'h1_800;
   localparam logic [12:0] HALT8K_START    = 13'h0_800;
   localparam logic [12:0] HALT16K_START   = 13'h1_800;

   // ==========================================
   // Control register command patterns
   // ==========================================
   localparam logic [6:0] CMD_PAGE_LOAD    = 7'h0_01;
   localparam logic [6:0] CMD_PAGE_ERASE   = 7'h0_03;
   localparam logic [6:0] CMD_PAGE_WRITE   = 7'h0_05;
   localparam logic [6:0] CMD_LOCK_WRITE   = 7'h0_09;
   localparam logic [6:0] CMD_REENABLE     = 7'h0_11;
   localparam logic [6:0] CMD_MASK         = 7'h1_F;

   typedef enum logic [2:0] {
      FSPS_OP_NONE,
      FSPS_OP_LOAD,
      FSPS_OP_ERASE,
      FSPS_OP_WRITE,
      FSPS_OP_LOCK,
      FSPS_OP_REEN
   } fsps_op_t;

   typedef enum {
      FSPS_IDLE,
      FSPS_ARMED,
      FSPS_BUSY
   } fsps_phase_t;

   typedef struct packed {
      logic [6:0]  ctrlBits;
      logic        ctrlWrite;
      logic        storeInstr;
      logic [15:0] zPointer;
      logic [15:0] dataWord;
   } fsps_req_t;

   typedef struct packed {
      logic                    flashStart;
      fsps_op_t                flashOp;
      logic [PAGE_IDX_W-1:0]   pageIndex;
      logic [WORD_IDX_W-1:0]   wordInPageIndex;
      logic [15:0]             loadWord;
   } fsps_flash_t;

endpackage : fsps_pkg

// file: src/fsps_flash_self_program.sv
`timescale 1ns/1ps

// Contract
// RULE1 - Reset does not abort running erase/write
// RULE2 - Operations timed 3.7 to 4.5 ms
// RULE3 - Page is 64 words, whole page ops
// RULE4 - 8K boot sections from size setting
// RULE5 - 16K boot sections, application below boot
// RULE6 - 8K halting region fixed at 0x800-0xFFF
// RULE7 - Busy op blocks readable region fetches
// RULE8 - Page index from pointer bits 13:7
// RULE9 - Word index from pointer bits 6:1
// RULE10 - Pointer bit 0 is byte select
// RULE11 - Software polls go bit before commands
// RULE12 - Software waits out EEPROM write first
// RULE13 - Software re-enables region after programming
// RULE14 - Buffer filled one word per command
// RULE15 - Software sleeps during low supply
// RULE16 - Store must follow control write within four
// RULE17 - Region busy flag held while busy
// RULE18 - EEPROM write blocks flash programming
// RULE19 - Halting region ops stall the core
module fsps_flash_self_program #(
   parameter int unsigned OP_CYCLES = fsps_pkg::OP_CYCLES_DFLT
) (
   input  wire logic                 mclk,
   input  wire logic                 reset,
   input  wire logic                 variant16k,
   input  wire logic                 boot_size_sel_hi,
   input  wire logic                 boot_size_sel_lo,
   input  wire logic                 eeprom_write_active,
   input  wire fsps_pkg::fsps_req_t  cpuReq,
   input  wire logic [12:0]          fetchAddr,
   output logic                      store_program_go,
   output logic                      region_busy_flag,
   output logic                      cpuStall,
   output logic                      fetchBlocked,
   output logic                      progRefused,
   output logic                      byteSelect,
   output logic [12:0]               bootStart,
   output logic [12:0]               haltStart,
   output fsps_pkg::fsps_flash_t     flashCmd
);

   // ==========================================
   // State
   // ==========================================
   typedef struct packed {
      fsps_pkg::fsps_phase_t  phase;
      fsps_pkg::fsps_op_t     op;
      logic [1:0]             armCnt;
      logic [fsps_pkg::TMR_W-1:0] timer;
      logic                   busy;
      logic                   haltOp;
      logic                   regionBusy;
      logic                   refused;
      logic                   byteSel;
      fsps_pkg::fsps_flash_t  cmd;
   } fsps_state_t;

   fsps_state_t state_reg;
   fsps_state_t state_next;

   logic [12:0]  bootStartW;
   logic [12:0]  haltStartW;
   logic [12:0]  targetAddr;
   fsps_pkg::fsps_op_t reqOp;
   logic [fsps_pkg::PAGE_IDX_W-1:0] zPage;
   logic [fsps_pkg::WORD_IDX_W-1:0] zWord;

   localparam logic [fsps_pkg::TMR_W-1:0] OP_LAST = fsps_pkg::TMR_W'(OP_CYCLES - 1); // [RULE2]

   // ==========================================
   // Section map
   // ==========================================
   always_comb begin
      bootStartW = fsps_pkg::BOOT8K_SZ0;
      if (variant16k) begin
         unique case ({boot_size_sel_hi, boot_size_sel_lo})
            2'b11: bootStartW = fsps_pkg::BOOT16K_SZ3; // [RULE5]
            2'b10: bootStartW = fsps_pkg::BOOT16K_SZ2; // [RULE5]
            2'b01: bootStartW = fsps_pkg::BOOT16K_SZ1; // [RULE5]
            2'b00: bootStartW = fsps_pkg::BOOT16K_SZ0; // [RULE5]
         endcase
      end else begin
         unique case ({boot_size_sel_hi, boot_size_sel_lo})
            2'b11: bootStartW = fsps_pkg::BOOT8K_SZ3; // [RULE4]
            2'b10: bootStartW = fsps_pkg::BOOT8K_SZ2; // [RULE4]
            2'b01: bootStartW = fsps_pkg::BOOT8K_SZ1; // [RULE4]
            2'b00: bootStartW = fsps_pkg::BOOT8K_SZ0; // [RULE4]
         endcase
      end
      // Halting boundary does not move with the boot size
      haltStartW = variant16k ? fsps_pkg::HALT16K_START : fsps_pkg::HALT8K_START; // [RULE6]
   end

   // ==========================================
   // Pointer fields
   // ==========================================
   always_comb begin
      zPage = cpuReq.zPointer[fsps_pkg::PAGE_IDX_LSB +: fsps_pkg::PAGE_IDX_W]; // [RULE8]
      zWord = cpuReq.zPointer[fsps_pkg::WORD_IDX_LSB +: fsps_pkg::WORD_IDX_W]; // [RULE9]
   end

   // ==========================================
   // Command decode
   // ==========================================
   always_comb begin
      unique case (cpuReq.ctrlBits & fsps_pkg::CMD_MASK)
         fsps_pkg::CMD_PAGE_LOAD:  reqOp = fsps_pkg::FSPS_OP_LOAD;
         fsps_pkg::CMD_PAGE_ERASE: reqOp = fsps_pkg::FSPS_OP_ERASE;
         fsps_pkg::CMD_PAGE_WRITE: reqOp = fsps_pkg::FSPS_OP_WRITE; // [RULE16]
         fsps_pkg::CMD_LOCK_WRITE: reqOp = fsps_pkg::FSPS_OP_LOCK;
         fsps_pkg::CMD_REENABLE:   reqOp = fsps_pkg::FSPS_OP_REEN;
         default:                  reqOp = fsps_pkg::FSPS_OP_NONE;
      endcase
      // Page base word address, word bits forced to page start
      targetAddr = {zPage, 6'h00}; // [RULE3] [RULE8]
   end

   // ==========================================
   // Sequencer
   // ==========================================
   always_comb begin
      state_next = state_reg;
      state_next.cmd.flashStart = 1'b0;
      state_next.refused = 1'b0;
      // Byte select tracks pointer bit 0 for program-memory loads
      state_next.byteSel = cpuReq.zPointer[0]; // [RULE10]

      unique case (state_reg.phase)
         fsps_pkg::FSPS_IDLE: begin
            if (cpuReq.ctrlWrite) begin
               if (eeprom_write_active) begin
                  state_next.refused = 1'b1; // [RULE18]
               end else if (reqOp != fsps_pkg::FSPS_OP_NONE) begin
                  state_next.phase  = fsps_pkg::FSPS_ARMED;
                  state_next.op     = reqOp;
                  state_next.armCnt = 2'(fsps_pkg::ARM_WINDOW - 1);
               end
            end
         end
         fsps_pkg::FSPS_ARMED: begin
            if (eeprom_write_active) begin
               // EEPROM write started while armed: drop the request
               state_next.refused = 1'b1; // [RULE18]
               state_next.phase   = fsps_pkg::FSPS_IDLE;
            end else if (cpuReq.storeInstr) begin
               state_next.cmd.flashOp         = state_reg.op;
               state_next.cmd.pageIndex       = zPage; // [RULE8]
               state_next.cmd.wordInPageIndex = zWord; // [RULE9]
               state_next.cmd.loadWord        = cpuReq.dataWord; // [RULE14]
               state_next.cmd.flashStart      = 1'b1;
               if (state_reg.op == fsps_pkg::FSPS_OP_LOAD) begin
                  // A page load frees the readable region immediately
                  state_next.regionBusy = 1'b0;
                  state_next.phase      = fsps_pkg::FSPS_IDLE;
               end else if (state_reg.op == fsps_pkg::FSPS_OP_REEN) begin
                  state_next.regionBusy = 1'b0; // [RULE17]
                  state_next.phase      = fsps_pkg::FSPS_IDLE;
               end else begin
                  state_next.phase  = fsps_pkg::FSPS_BUSY;
                  state_next.busy   = 1'b1;
                  state_next.timer  = '0;
                  if (state_reg.op == fsps_pkg::FSPS_OP_LOCK) begin
                     // Lock write never stalls the core and leaves the region busy flag as it was
                     state_next.haltOp = 1'b0;
                  end else if (targetAddr >= haltStartW) begin
                     state_next.haltOp = 1'b1; // [RULE19]
                  end else begin
                     state_next.haltOp     = 1'b0;
                     state_next.regionBusy = 1'b1; // [RULE17]
                  end
               end
            end else if (state_reg.armCnt == 2'h0) begin
               state_next.phase = fsps_pkg::FSPS_IDLE; // [RULE16]
            end else begin
               state_next.armCnt = state_reg.armCnt - 2'h1;
            end
         end
         fsps_pkg::FSPS_BUSY: begin
            if (state_reg.timer == OP_LAST) begin // [RULE2]
               state_next.phase  = fsps_pkg::FSPS_IDLE;
               state_next.busy   = 1'b0;
               state_next.haltOp = 1'b0;
            end else begin
               state_next.timer = state_reg.timer + 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         if (state_reg.busy == 1'b1) begin
            // Running erase/write carries on; only the refusal pulse is dropped
            state_reg         <= state_next; // [RULE1]
            state_reg.refused <= 1'b0;
         end else begin
            // Also taken while the state is still unknown after power-up
            state_reg <= '0;
         end
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Outputs
   // ==========================================
   always_comb begin
      store_program_go = (state_reg.phase != fsps_pkg::FSPS_IDLE); // [RULE11]
      region_busy_flag = state_reg.regionBusy; // [RULE17]
      cpuStall         = state_reg.busy && state_reg.haltOp; // [RULE19]
      // Lock write blocks no fetch unless the region busy flag is still set from an earlier op
      fetchBlocked     = state_reg.busy && state_reg.regionBusy
                         && (fetchAddr < haltStartW); // [RULE7]
      progRefused      = state_reg.refused;
      byteSelect       = state_reg.byteSel;
      bootStart        = bootStartW;
      haltStart        = haltStartW;
      flashCmd         = state_reg.cmd;
   end

endmodule : fsps_flash_self_program

// file: verification/fsps_flash_self_program_properties.sv
`timescale 1ns/1ps
module fsps_checker #(
   parameter int unsigned OP_CYCLES = 20
) (
   input wire logic                  mclk,
   input wire logic                  reset,
   input wire logic                  variant16k,
   input wire logic                  boot_size_sel_hi,
   input wire logic                  boot_size_sel_lo,
   input wire logic                  eeprom_write_active,
   input wire fsps_pkg::fsps_req_t   cpuReq,
   input wire logic [12:0]           fetchAddr,
   input wire logic                  store_program_go,
   input wire logic                  region_busy_flag,
   input wire logic                  cpuStall,
   input wire logic                  fetchBlocked,
   input wire logic                  progRefused,
   input wire logic                  byteSelect,
   input wire logic [12:0]           bootStart,
   input wire logic [12:0]           haltStart,
   input wire fsps_pkg::fsps_flash_t flashCmd
);
   localparam int T_LO = OP_CYCLES - 10;
   localparam int T_HI = OP_CYCLES - 6;
   logic timed;
   logic inHalt;
   assign timed = flashCmd.flashStart && (flashCmd.flashOp == fsps_pkg::FSPS_OP_ERASE
                  || flashCmd.flashOp == fsps_pkg::FSPS_OP_WRITE);
   assign inHalt = {flashCmd.pageIndex, 6'h00} >= haltStart;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   sequence s_arm;
      cpuReq.ctrlWrite && !store_program_go && !eeprom_write_active && cpuReq.ctrlBits == 7'h05;
   endsequence
   sequence s_no_store;
      !cpuReq.storeInstr [*4];
   endsequence
   // ==========================================
   // Sequencing and mapping
   // ==========================================
   a_arm_go: assert property (s_arm |=> store_program_go) else $error("go not raised");
   a_arm_lapse: assert property (s_arm ##1 s_no_store |-> ##[1:2] !store_program_go)
      else $error("arming did not lapse");
   a_op_time: assert property (
      timed |-> store_program_go [*8] ##[T_LO:T_HI] $fell(store_program_go))
      else $error("operation length wrong");
   a_page_idx: assert property (
      flashCmd.flashStart |-> flashCmd.pageIndex == $past(cpuReq.zPointer[13:7]))
      else $error("page index wrong");
   a_word_idx: assert property (
      flashCmd.flashStart |-> flashCmd.wordInPageIndex == $past(cpuReq.zPointer[6:1]))
      else $error("word index wrong");
   a_ee_refuse: assert property (
      cpuReq.ctrlWrite && eeprom_write_active && !store_program_go
      |=> progRefused && !store_program_go)
      else $error("programming not refused");
   a_rww_busy: assert property (timed && !inHalt |-> region_busy_flag && !cpuStall)
      else $error("readable region op wrong");
   a_halt_stall: assert property (timed && inHalt |-> cpuStall) else $error("no stall");
   a_flag_hold: assert property (region_busy_flag && !cpuReq.storeInstr |=> region_busy_flag)
      else $error("busy flag dropped");
   a_fetch_block: assert property (
      timed && !inHalt |=> (fetchBlocked == (fetchAddr < haltStart)) [*8])
      else $error("fetch blocking wrong");
   a_boot_map: assert property (
      bootStart == {variant16k, 12'h000} + 13'h1000
                   - (13'h0100 << ~{boot_size_sel_hi, boot_size_sel_lo}))
      else $error("boot start wrong");
   a_halt_map: assert property (
      haltStart == (variant16k ? 13'h1800 : 13'h0800))
      else $error("halt start wrong");
   a_byte_sel: assert property (
      !$past(reset) |-> byteSelect == $past(cpuReq.zPointer[0]))
      else $error("byte select wrong");
   a_reen_clear: assert property (
      flashCmd.flashStart && flashCmd.flashOp == fsps_pkg::FSPS_OP_REEN
      |-> !region_busy_flag)
      else $error("busy flag not cleared");
   a_lock_free: assert property (
      flashCmd.flashStart && flashCmd.flashOp == fsps_pkg::FSPS_OP_LOCK
      |-> store_program_go && !cpuStall)
      else $error("lock write stalled");
endmodule : fsps_checker

bind fsps_flash_self_program fsps_checker #(.OP_CYCLES(OP_CYCLES)) u_fsps_checker (
   .mclk(mclk), .reset(reset), .variant16k(variant16k), .boot_size_sel_hi(boot_size_sel_hi),
   .boot_size_sel_lo(boot_size_sel_lo), .eeprom_write_active(eeprom_write_active),
   .cpuReq(cpuReq), .fetchAddr(fetchAddr), .store_program_go(store_program_go),
   .region_busy_flag(region_busy_flag), .cpuStall(cpuStall), .fetchBlocked(fetchBlocked),
   .progRefused(progRefused), .byteSelect(byteSelect), .bootStart(bootStart),
   .haltStart(haltStart), .flashCmd(flashCmd));

// file: verification/fsps_cpu_model.sv
`timescale 1ns/1ps
module fsps_cpu_model (
   input  wire logic           mclk,
   input  wire logic           goFlag,
   input  wire logic           eeBusy,
   output fsps_pkg::fsps_req_t cpuReq,
   output logic                stuck
);
   // Core stays quiet until the bench lets it run, as in power-down
   initial cpuReq = '0;
   initial stuck = 1'b0;
   // ==========================================
   // One store-program command; gap above 4 lets the arming lapse
   // ==========================================
   task automatic spm(input logic [6:0] bits, input logic [15:0] z, input logic [15:0] d,
                      input int gap, input bit skipEe);
      for (int i = 0; i < 200 && goFlag; i++) @(negedge mclk);
      for (int i = 0; i < 200 && eeBusy && !skipEe; i++) @(negedge mclk);
      if (goFlag || (eeBusy && !skipEe)) stuck = 1'b1;
      @(negedge mclk);
      cpuReq.ctrlBits = bits;
      cpuReq.zPointer = {z[15:1], 1'b0};
      cpuReq.dataWord = d;
      cpuReq.ctrlWrite = 1'b1;
      @(negedge mclk);
      cpuReq.ctrlWrite = 1'b0;
      repeat (gap - 1) @(negedge mclk);
      cpuReq.storeInstr = 1'b1;
      @(negedge mclk);
      cpuReq.storeInstr = 1'b0;
   endtask : spm
   // Pointer move for a program-memory load; Z0 picks the byte
   task automatic point(input logic [15:0] z);
      @(negedge mclk);
      cpuReq.zPointer = z;
   endtask : point
endmodule : fsps_cpu_model

// file: verification/fsps_flash_self_program_bench.sv
`timescale 1ns/1ps
module fsps_flash_self_program_bench;
   logic                  mclk = 1'b0;
   logic                  reset = 1'b1;
   logic                  variant16k = 1'b0;
   logic                  boot_size_sel_hi = 1'b0;
   logic                  boot_size_sel_lo = 1'b0;
   logic                  eeprom_write_active = 1'b0;
   logic [12:0]           fetchAddr = 13'h0000;
   fsps_pkg::fsps_req_t   cpuReq;
   logic                  go;
   logic                  busyFlag;
   logic                  stall;
   logic                  blocked;
   logic [12:0]           bootStart;
   logic [12:0]           haltStart;
   fsps_pkg::fsps_flash_t flashCmd;
   logic                  refusedPulse;
   logic                  byteSel;
   logic                  stuck;
   int                    nRefused = 0;
   int                    n_mismatch = 0;
   int                    comparisons = 0;
   // Row: {variant, size setting, boot start, halt start}
   logic [28:0]           rows [8] = '{
      {3'h0, 13'h0800, 13'h0800}, {3'h1, 13'h0C00, 13'h0800}, {3'h2, 13'h0E00, 13'h0800},
      {3'h3, 13'h0F00, 13'h0800}, {3'h4, 13'h1800, 13'h1800}, {3'h5, 13'h1C00, 13'h1800},
      {3'h6, 13'h1E00, 13'h1800}, {3'h7, 13'h1F00, 13'h1800}};

   always #5 mclk = ~mclk;

   fsps_flash_self_program #(.OP_CYCLES(20)) u_fsps_flash_self_program (
      .mclk(mclk), .reset(reset), .variant16k(variant16k), .boot_size_sel_hi(boot_size_sel_hi),
      .boot_size_sel_lo(boot_size_sel_lo), .eeprom_write_active(eeprom_write_active),
      .cpuReq(cpuReq), .fetchAddr(fetchAddr), .store_program_go(go),
      .region_busy_flag(busyFlag), .cpuStall(stall), .fetchBlocked(blocked),
      .progRefused(refusedPulse), .byteSelect(byteSel), .bootStart(bootStart),
      .haltStart(haltStart),
      .flashCmd(flashCmd));
   fsps_cpu_model u_fsps_cpu_model (.mclk(mclk), .goFlag(go),
      .eeBusy(eeprom_write_active), .cpuReq(cpuReq), .stuck(stuck));
   // Refusal lasts one cycle; count it so a task can look afterwards
   always @(posedge mclk) nRefused <= nRefused + int'(refusedPulse);

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   task automatic wait_idle();
      for (int i = 0; i < 100 && go !== 1'b0; i++) @(negedge mclk);
      chk("idle", 16'h0000, {15'h0000, go});
      if (go !== 1'b0) print_verdict();
   endtask : wait_idle

   initial begin
      repeat (16) @(negedge mclk);
      reset = 1'b0;
      chk("resetState", 16'h0000, {12'h000, go, busyFlag, stall, flashCmd.flashStart});
      for (int r = 0; r < 8; r++) begin
         @(negedge mclk);
         {variant16k, boot_size_sel_hi, boot_size_sel_lo} = rows[r][28:26];
         @(negedge mclk);
         chk("bootStart", {3'h0, rows[r][25:13]}, {3'h0, bootStart});
         chk("haltStart", {3'h0, rows[r][12:0]}, {3'h0, haltStart});
      end
      $display("test map done");
      variant16k = 1'b0;
      u_fsps_cpu_model.point(16'h0001);
      @(negedge mclk);
      chk("byteSelect", 16'h0001, {15'h0000, byteSel});
      u_fsps_cpu_model.point(16'h0000);
      @(negedge mclk);
      chk("byteSelect", 16'h0000, {15'h0000, byteSel});
      // ==========================================
      // Readable-region write, then a page load that frees the region
      // ==========================================
      u_fsps_cpu_model.spm(7'h05, 16'h0180, 16'h0000, 1, 1'b0);
      chk("pageIndex", 16'h0003, {9'h000, flashCmd.pageIndex});
      chk("busyFlag", 16'h0001, {15'h0000, busyFlag});
      fetchAddr = 13'h07FF;
      @(negedge mclk);
      chk("blocked", 16'h0001, {15'h0000, blocked});
      fetchAddr = 13'h0800;
      @(negedge mclk);
      chk("blocked", 16'h0000, {15'h0000, blocked});
      wait_idle();
      chk("busyFlag", 16'h0001, {15'h0000, busyFlag});
      u_fsps_cpu_model.spm(7'h01, 16'h007E, 16'hA5C3, 1, 1'b0);
      chk("wordIndex", 16'h003F, {10'h000, flashCmd.wordInPageIndex});
      chk("loadWord", 16'hA5C3, flashCmd.loadWord);
      chk("busyFlag", 16'h0000, {15'h0000, busyFlag});
      $display("test write done");
      // Last halting page, store at the final legal cycle, reset mid-op
      u_fsps_cpu_model.spm(7'h03, 16'h1F80, 16'h0000, 4, 1'b0);
      chk("pageIndex", 16'h003F, {9'h000, flashCmd.pageIndex});
      chk("stall", 16'h0001, {15'h0000, stall});
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      chk("stallAfterReset", 16'h0001, {15'h0000, stall});
      wait_idle();
      chk("stall", 16'h0000, {15'h0000, stall});
      $display("test erase done");
      u_fsps_cpu_model.spm(7'h05, 16'h0180, 16'h0000, 5, 1'b0);
      chk("lapsedStart", 16'h0000, {13'h0000, go, busyFlag, flashCmd.flashStart});
      wait_idle();
      eeprom_write_active = 1'b1;
      u_fsps_cpu_model.spm(7'h03, 16'h0180, 16'h0000, 1, 1'b1);
      chk("refusedStart", 16'h0000, {13'h0000, go, busyFlag, flashCmd.flashStart});
      eeprom_write_active = 1'b0;
      chk("refusedPulse", 16'h0001, nRefused[15:0]);
      $display("test refuse done");
      // Lock write: timed, but no stall and no blocked fetch
      fetchAddr = 13'h0000;
      u_fsps_cpu_model.spm(7'h09, 16'h0001, 16'h00C3, 1, 1'b0);
      chk("lockOp", 16'h0008, {12'h000, go, stall, busyFlag, blocked});
      wait_idle();
      // Readable-region erase, then re-enable before using the region again
      u_fsps_cpu_model.spm(7'h03, 16'h0040, 16'h0000, 2, 1'b0);
      chk("blocked", 16'h0001, {15'h0000, blocked});
      wait_idle();
      chk("busyFlag", 16'h0001, {15'h0000, busyFlag});
      u_fsps_cpu_model.spm(7'h11, 16'h0000, 16'h0000, 1, 1'b0);
      chk("busyFlag", 16'h0000, {15'h0000, busyFlag});
      chk("modelStuck", 16'h0000, {15'h0000, stuck});
      $display("test reenable done");
      print_verdict();
   end
endmodule : fsps_flash_self_program_bench
